//--- logic/ccp_pkg.sv
// Package with register map, field layout and encodings of the clock control block
package ccp_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int PREDIV_W = 8;
  localparam int MULT_W   = 15;
  localparam int USBDIV_W = 4;
  localparam int SEL_W    = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_SRC_SEL  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PLL_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PLL_CFG  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_USB_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CLKOUT   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_OSC_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] REG_PWR_CTRL = 8'h1C;

  // Field positions
  localparam int PLL_EN_BIT     = 0;
  localparam int PLL_CONN_BIT   = 1;
  localparam int CFG_N_LSB      = 0;
  localparam int CFG_M_LSB      = 16;
  localparam int USB_EN_BIT     = 0;
  localparam int USB_DIV_LSB    = 4;
  localparam int CLKOUT_SEL_LSB = 0;
  localparam int CLKOUT_EN_BIT  = 8;
  localparam int OSC_EN_BIT     = 0;
  localparam int PWR_DOWN_BIT   = 0;
  localparam int SRC_LSB        = 0;

  // Status layout
  localparam int ST_PLL_EN     = 0;
  localparam int ST_PLL_CONN   = 1;
  localparam int ST_PLL_LOCK   = 2;
  localparam int ST_USB_EN     = 3;
  localparam int ST_USB_LOCK   = 4;
  localparam int ST_OSC_READY  = 5;
  localparam int ST_USB_ACTIVE = 6;
  localparam int ST_SRC_LSB    = 8;

  // Reset values
  localparam logic [PREDIV_W-1:0] RST_PREDIV_M1 = 8'h00;
  localparam logic [MULT_W-1:0]   RST_MULT_M1   = 15'h0000;
  localparam logic [USBDIV_W-1:0] RST_USBDIV_M1 = 4'h5;
  localparam int                  OSC_WAKE_CYCLES = 4096;

  typedef enum logic [1:0] {
    SRC_IRC      = 2'h0,
    SRC_MAIN_OSC = 2'h1,
    SRC_RTC      = 2'h2
  } ccp_src_t;

  typedef enum logic [2:0] {
    CO_CORE     = 3'h0,
    CO_IRC      = 3'h1,
    CO_MAIN_OSC = 3'h2,
    CO_RTC      = 3'h3,
    CO_USB      = 3'h4
  } ccp_clkout_t;

  typedef enum logic [3:0] {
    PLL_OFF       = 4'h1,
    PLL_LOCKING   = 4'h2,
    PLL_LOCKED    = 4'h4,
    PLL_CONNECTED = 4'h8
  } ccp_pll_state_t;

endpackage : ccp_pkg

//--- logic/ccp_div_if.sv
// Interface joining the controller to a programmable tick divider
`timescale 1ns/10ps
interface ccp_div_if #(parameter int W = 8);
  logic         tick_in;
  logic [W-1:0] div_m1;
  logic         tick_out;

  modport ctrl (output tick_in, output div_m1, input tick_out);
  modport div  (input tick_in, input div_m1, output tick_out);
endinterface : ccp_div_if

//--- logic/ccp_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module ccp_sync2 (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : ccp_sync2

//--- logic/ccp_tick_div.sv
// Programmable divider: one output tick per (div_m1 + 1) input ticks
`timescale 1ns/10ps
module ccp_tick_div #(parameter int W = 8) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  ccp_div_if.div    dv
);
  logic [W-1:0] count;
  wire          wrap = (count >= dv.div_m1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count       <= '0;
      dv.tick_out <= 1'b0;
    end else begin
      dv.tick_out <= dv.tick_in & wrap;
      if (dv.tick_in) begin
        count <= wrap ? '0 : count + 1'b1;
      end
    end
  end
endmodule : ccp_tick_div

//--- logic/ccp_clock_ctrl.sv
// Clock source selection, main and USB clock path control, clock output and wake-up timer
//
// Overview of operation
// - after reset the core clock comes from the internal RC oscillator until changed.
// - software picks main, internal RC or RTC oscillator as main PLL reference.
// - the reference is pre-divided by a programmable value from 1 to 256.
// - oscillator output divided by 1 to 32768, compared with reference by a PFD.
// - main PLL is off and bypassed after reset and on power-down entry.
// - PLL is enabled by software: configure, enable, wait lock, then connect.
// - the USB PLL uses the main oscillator and feeds only the USB clock.
// - the USB PLL stays disabled after reset until software enables it.
// - with the USB PLL disabled, USB clock is derived from the main PLL.
// - the USB clock output has a 50 percent duty cycle.
// - clock output pin selects core, internal RC, main osc, RTC or USB clock.
// - at power-up and on wake the core runs from the internal RC oscillator; wake leaves a connected main PLL driving the core.
// - a wake-up timer flags the main oscillator ready after its start-up count.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module ccp_clock_ctrl
  import ccp_pkg::*;
#(
  parameter int WAKE_CYCLES = OSC_WAKE_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              irc_tick,
  input  wire logic              main_osc_tick,
  input  wire logic              rtc_tick,
  input  wire logic              cco_tick,
  input  wire logic              main_pll_lock,
  input  wire logic              usb_pll_tick,
  input  wire logic              usb_pll_lock,
  input  wire logic              wake_event,
  output logic                   main_osc_en,
  output logic      [1:0]        main_pll_src,
  output logic                   main_pll_en,
  output logic                   main_pll_connect,
  output logic                   pfd_up,
  output logic                   pfd_dn,
  output logic                   core_clock,
  output logic                   usb_pll_en,
  output logic                   usb_clk,
  output logic                   clkout_pin
);

  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);

  // Selects one of the three oscillator ticks by source code
  function automatic logic pick_osc(input logic [1:0] sel, input logic internal_rc_osc,
                                    input logic osc, input logic rtc);
    pick_osc = (sel == SRC_MAIN_OSC) ? osc :
               (sel == SRC_RTC)      ? rtc : internal_rc_osc;
  endfunction : pick_osc

  // Register write decode
  wire wr_src    = reg_wr && (reg_addr == REG_SRC_SEL);
  wire wr_ctrl   = reg_wr && (reg_addr == REG_PLL_CTRL);
  wire wr_cfg    = reg_wr && (reg_addr == REG_PLL_CFG);
  wire wr_usb    = reg_wr && (reg_addr == REG_USB_CTRL);
  wire wr_clkout = reg_wr && (reg_addr == REG_CLKOUT);
  wire wr_osc    = reg_wr && (reg_addr == REG_OSC_CTRL);
  wire wr_pwr    = reg_wr && (reg_addr == REG_PWR_CTRL);

  wire pd_enter  = wr_pwr && reg_wdata[PWR_DOWN_BIT];
  wire [1:0] wr_src_val = reg_wdata[SRC_LSB +: 2];
  wire wr_en_bit   = reg_wdata[PLL_EN_BIT];
  wire wr_conn_bit = reg_wdata[PLL_CONN_BIT];

  // Control state
  logic [1:0]          src_sel;
  logic [PREDIV_W-1:0] prediv_m1;
  logic [MULT_W-1:0]   mult_m1;
  logic [USBDIV_W-1:0] usbdiv_m1;
  logic [SEL_W-1:0]    clkout_sel;
  logic                clkout_en;
  logic                osc_ready;
  logic [WAKE_W-1:0]   wake_count;
  ccp_pll_state_t      pll_state;
  ccp_pll_state_t      next_pll_state;

  // Synchronised lock indications
  logic main_lock_s;
  logic usb_lock_s;

  ccp_sync2 u_main_lock (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .d        (main_pll_lock),
    .q        (main_lock_s)
  );

  ccp_sync2 u_usb_lock (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .d        (usb_pll_lock),
    .q        (usb_lock_s)
  );

  // Pre-divider, feedback divider and USB fallback divider
  ccp_div_if #(.W(PREDIV_W)) ref_if ();
  ccp_div_if #(.W(MULT_W))   fb_if ();
  ccp_div_if #(.W(USBDIV_W)) usb_if ();

  wire ref_tick = pick_osc(src_sel, irc_tick, main_osc_tick, rtc_tick);

  assign ref_if.tick_in = ref_tick & main_pll_en;
  assign ref_if.div_m1  = prediv_m1;
  assign fb_if.tick_in  = cco_tick & main_pll_en;
  assign fb_if.div_m1   = mult_m1;
  assign usb_if.tick_in = cco_tick & main_pll_en;
  assign usb_if.div_m1  = usbdiv_m1;

  ccp_tick_div #(.W(PREDIV_W)) u_prediv (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .dv       (ref_if)
  );

  ccp_tick_div #(.W(MULT_W)) u_fbdiv (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .dv       (fb_if)
  );

  ccp_tick_div #(.W(USBDIV_W)) u_usbdiv (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .dv       (usb_if)
  );

  // Main PLL sequencing: enable, lock, connect
  always_comb begin
    next_pll_state = pll_state;
    unique case (pll_state)
      PLL_OFF: begin
        if (wr_ctrl && wr_en_bit) begin
          next_pll_state = PLL_LOCKING;
        end
      end
      PLL_LOCKING: begin
        if (wr_ctrl && !wr_en_bit) begin
          next_pll_state = PLL_OFF;
        end else if (main_lock_s) begin
          next_pll_state = PLL_LOCKED;
        end
      end
      PLL_LOCKED: begin
        if (wr_ctrl && !wr_en_bit) begin
          next_pll_state = PLL_OFF;
        end else if (!main_lock_s) begin
          next_pll_state = PLL_LOCKING;
        end else if (wr_ctrl && wr_conn_bit) begin
          next_pll_state = PLL_CONNECTED;
        end
      end
      PLL_CONNECTED: begin
        if (wr_ctrl && !wr_en_bit) begin
          next_pll_state = PLL_OFF;
        end else if (!main_lock_s) begin
          next_pll_state = PLL_LOCKING;
        end else if (wr_ctrl && !wr_conn_bit) begin
          next_pll_state = PLL_LOCKED;
        end
      end
      default: next_pll_state = PLL_OFF;
    endcase
    if (pd_enter) begin
      next_pll_state = PLL_OFF;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pll_state        <= PLL_OFF;
      main_pll_en      <= 1'b0;
      main_pll_connect <= 1'b0;
    end else begin
      pll_state        <= next_pll_state;
      main_pll_en      <= (next_pll_state != PLL_OFF);
      main_pll_connect <= (next_pll_state == PLL_CONNECTED);
    end
  end

  // Source select; main osc refused until its wake-up timer has run out
  wire src_legal = (wr_src_val == SRC_IRC) || (wr_src_val == SRC_RTC) ||
                   ((wr_src_val == SRC_MAIN_OSC) && osc_ready);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      src_sel <= SRC_IRC;
    end else if (pd_enter || wake_event) begin
      src_sel <= SRC_IRC;
    end else if (wr_src && src_legal) begin
      src_sel <= wr_src_val;
    end
  end

  assign main_pll_src = src_sel;

  // Pre-divider and feedback divider only change while the PLL is off, so a running loop is never disturbed
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prediv_m1 <= RST_PREDIV_M1;
      mult_m1   <= RST_MULT_M1;
    end else if (wr_cfg && (pll_state == PLL_OFF)) begin
      prediv_m1 <= reg_wdata[CFG_N_LSB +: PREDIV_W];
      mult_m1   <= reg_wdata[CFG_M_LSB +: MULT_W];
    end
  end

  // Phase-frequency detector on the divided reference and feedback
  always_ff @(posedge core_clk) begin
    if (sys_rst || !main_pll_en) begin
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
    end else if (ref_if.tick_out && !fb_if.tick_out) begin
      pfd_up <= !pfd_dn;
      pfd_dn <= 1'b0;
    end else if (fb_if.tick_out && !ref_if.tick_out) begin
      pfd_dn <= !pfd_up;
      pfd_up <= 1'b0;
    end
  end

  // Main oscillator enable and wake-up timer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      main_osc_en <= 1'b0;
    end else if (pd_enter) begin
      main_osc_en <= 1'b0;
    end else if (wr_osc) begin
      main_osc_en <= reg_wdata[OSC_EN_BIT];
    end
  end

  // Counts oscillator ticks so the main osc cannot be selected until its start-up count has run out
  always_ff @(posedge core_clk) begin
    if (sys_rst || !main_osc_en) begin
      wake_count <= '0;
      osc_ready  <= 1'b0;
    end else if (main_osc_tick && !osc_ready) begin
      wake_count <= wake_count + 1'b1;
      osc_ready  <= (wake_count == WAKE_LAST);
    end
  end

  // USB clock path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      usb_pll_en <= 1'b0;
      usbdiv_m1  <= RST_USBDIV_M1;
    end else if (pd_enter) begin
      usb_pll_en <= 1'b0;
    end else if (wr_usb) begin
      usb_pll_en <= reg_wdata[USB_EN_BIT];
      usbdiv_m1  <= reg_wdata[USB_DIV_LSB +: USBDIV_W];
    end
  end

  // Dedicated PLL only once locked; the main PLL path covers the gap
  wire usb_pll_active = usb_pll_en && usb_lock_s;
  wire usb_tick = usb_pll_active ? usb_pll_tick : usb_if.tick_out;

  // Toggling on every source tick keeps high and low halves equal
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      usb_clk <= 1'b0;
    end else if (usb_tick) begin
      usb_clk <= !usb_clk;
    end
  end

  // Core clock: bypassed reference until the PLL is connected
  wire core_tick = main_pll_connect ? cco_tick : ref_tick;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      core_clock <= 1'b0;
    end else if (core_tick) begin
      core_clock <= !core_clock;
    end
  end

  // Clock output pin
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkout_sel <= CO_CORE;
      clkout_en  <= 1'b0;
    end else if (wr_clkout) begin
      clkout_sel <= reg_wdata[CLKOUT_SEL_LSB +: SEL_W];
      clkout_en  <= reg_wdata[CLKOUT_EN_BIT];
    end
  end

  wire clkout_tick = (clkout_sel == CO_CORE)     ? core_tick     :
                     (clkout_sel == CO_IRC)      ? irc_tick      :
                     (clkout_sel == CO_MAIN_OSC) ? main_osc_tick :
                     (clkout_sel == CO_RTC)      ? rtc_tick      :
                     (clkout_sel == CO_USB)      ? usb_tick      : 1'b0;

  always_ff @(posedge core_clk) begin
    if (sys_rst || !clkout_en) begin
      clkout_pin <= 1'b0;
    end else if (clkout_tick) begin
      clkout_pin <= !clkout_pin;
    end
  end

  // Read path
  wire [DATA_W-1:0] status_word = {
    22'h000000,
    src_sel,
    1'b0,
    usb_pll_active,
    osc_ready,
    usb_lock_s,
    usb_pll_en,
    main_lock_s,
    main_pll_connect,
    main_pll_en
  };

  wire [DATA_W-1:0] rd_mux =
    (reg_addr == REG_SRC_SEL)  ? {30'h00000000, src_sel} :
    (reg_addr == REG_PLL_CTRL) ? {30'h00000000, main_pll_connect, main_pll_en} :
    (reg_addr == REG_PLL_CFG)  ? {1'b0, mult_m1, 8'h00, prediv_m1} :
    (reg_addr == REG_STATUS)   ? status_word :
    (reg_addr == REG_USB_CTRL) ? {24'h000000, usbdiv_m1, 3'h0, usb_pll_en} :
    (reg_addr == REG_CLKOUT)   ? {23'h000000, clkout_en, 5'h00, clkout_sel} :
    (reg_addr == REG_OSC_CTRL) ? {31'h00000000, main_osc_en} : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : ccp_clock_ctrl

//--- verification/ccp_clock_ctrl_checker.sv
// Port-level assertions for the clock control block
`timescale 1ns/10ps
module ccp_clock_ctrl_checker
  import ccp_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              irc_tick,
  input wire logic              main_osc_tick,
  input wire logic              rtc_tick,
  input wire logic              cco_tick,
  input wire logic              main_pll_lock,
  input wire logic              wake_event,
  input wire logic              main_osc_en,
  input wire logic [1:0]        main_pll_src,
  input wire logic              main_pll_en,
  input wire logic              main_pll_connect,
  input wire logic              usb_pll_en,
  input wire logic              core_clock
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  wire logic w_src  = reg_wr && reg_addr == REG_SRC_SEL;
  wire logic src_ok = w_src && !reg_wdata[0];
  wire logic src_3  = w_src && reg_wdata[1:0] == 2'h3;
  wire logic w_pll  = reg_wr && reg_addr == REG_PLL_CTRL;
  wire logic w_osc  = reg_wr && reg_addr == REG_OSC_CTRL;
  wire logic w_pdn  = reg_wr && reg_addr == REG_PWR_CTRL && reg_wdata[0];
  wire logic any_tk = irc_tick | main_osc_tick | rtc_tick | cco_tick;

  AST_RESET_VALUES: assert property ($past(sys_rst) |-> !main_pll_en && !main_pll_connect
    && !usb_pll_en && !main_osc_en && main_pll_src == SRC_IRC) else $error("bad state after reset");
  AST_SRC_TAKEN: assert property ($past(src_ok) |-> main_pll_src == $past(reg_wdata[1:0]))
    else $error("source select not taken");
  AST_SRC_REFUSED: assert property ($past(src_3) |-> $stable(main_pll_src))
    else $error("reserved source accepted");
  AST_EN_WRITE: assert property ($past(w_pll) |-> main_pll_en == $past(reg_wdata[0]))
    else $error("pll enable not following write");
  AST_CONN_NEEDS_EN: assert property (main_pll_connect |-> main_pll_en)
    else $error("connected while disabled");
  AST_CONN_NEEDS_LOCK: assert property ($rose(main_pll_connect) |-> $past(main_pll_lock, 3))
    else $error("connected without lock");
  AST_LOCK_LOSS: assert property (!main_pll_lock [*5] |-> !main_pll_connect)
    else $error("still connected after lock loss");
  AST_POWER_DOWN: assert property ($past(w_pdn) |-> !main_pll_en && !main_pll_connect
    && !usb_pll_en && !main_osc_en && main_pll_src == SRC_IRC) else $error("power-down incomplete");
  AST_WAKE_IRC: assert property ($past(wake_event) |-> main_pll_src == SRC_IRC)
    else $error("wake did not select internal RC");
  AST_OSC_WRITE: assert property ($past(w_osc) |-> main_osc_en == $past(reg_wdata[0]))
    else $error("oscillator enable not following write");
  // Allows two cycles of tick-to-toggle delay
  AST_CORE_QUIET: assert property (!$past(any_tk) && !$past(any_tk, 2) |-> $stable(core_clock))
    else $error("core clock moved without a tick");

  cover property ($rose(main_pll_connect));
  cover property (main_pll_src == SRC_MAIN_OSC);
  cover property ($rose(usb_pll_en));
endmodule : ccp_clock_ctrl_checker

bind ccp_clock_ctrl ccp_clock_ctrl_checker u_chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .irc_tick, .main_osc_tick, .rtc_tick, .cco_tick, .main_pll_lock, .wake_event,
  .main_osc_en, .main_pll_src, .main_pll_en, .main_pll_connect, .usb_pll_en, .core_clock);

//--- verification/tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/10ps
module tb
  import ccp_pkg::*;
;
  logic              core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic              lock = 1'b0, wake = 1'b0, det = 1'b0, ulk = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, m_cfg = '0;
  logic [4:0]        tk = '0, mask = '0;
  logic [2:0]        pv = '0;
  logic [1:0]        src, m_src = '0;
  logic              osc_en, pll_en, conn, up, dn, core, usb_en, usb, pin;
  logic              m_en = 1'b0, m_conn = 1'b0, m_osc = 1'b0, m_rdy = 1'b0;
  logic              m_usb = 1'b0, m_lk = 1'b0;
  logic [31:0]       rs = 32'h1E;
  wire logic [2:0]   ov = {pin, usb, core};
  int                err_count = 0, comparisons = 0, tc[5], cc[3], t0[5], c0[3];
  int                idx[5] = '{1, 0, 1, 2, 4};

  ccp_clock_ctrl #(.WAKE_CYCLES(8)) u_ccp_clock_ctrl (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irc_tick(tk[0]),
    .main_osc_tick(tk[1]), .rtc_tick(tk[2]), .cco_tick(tk[3]), .main_pll_lock(lock),
    .usb_pll_tick(tk[4]), .usb_pll_lock(ulk), .wake_event(wake), .main_osc_en(osc_en),
    .main_pll_src(src), .main_pll_en(pll_en), .main_pll_connect(conn), .pfd_up(up),
    .pfd_dn(dn), .core_clock(core), .usb_pll_en(usb_en), .usb_clk(usb), .clkout_pin(pin));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  initial forever #4 core_clk = ~core_clk;

  // Ticks and toggles are tallied on the same edge the design samples them
  always @(posedge core_clk) begin
    rs <= xs(rs);
    tk <= mask & (det ? 5'h1F : rs[4:0]);
    pv <= ov;
    for (int i = 0; i < 5; i++) tc[i] += int'(tk[i]);
    for (int j = 0; j < 3; j++) cc[j] += int'(ov[j] !== pv[j]);
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    case (a)
      REG_SRC_SEL: if (d[1:0] != 2'h3 && (d[1:0] != 2'h1 || m_rdy)) m_src = d[1:0];
      REG_PLL_CTRL: begin
        m_en = d[0];
        m_conn = d[0] & d[1] & m_lk;
      end
      REG_PLL_CFG: if (!m_en) m_cfg = d & 32'h7FFF00FF;
      REG_USB_CTRL: m_usb = d[0];
      REG_OSC_CTRL: m_osc = d[0];
      REG_PWR_CTRL: if (d[0]) {m_en, m_conn, m_src, m_osc, m_usb} = '0;
      default: ;
    endcase
    // Idle edge, so a following write never re-drives the strobe in this step
    @(posedge core_clk);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // Read data stand only in this cycle, so look mid-cycle
    @(negedge core_clk);
    chk(reg_rdata & msk, exp & msk);
    @(posedge core_clk);
  endtask : rdc

  // USB lock bits follow the bench's lock level, which has settled long before
  task automatic st;
    rdc(REG_STATUS, {22'h0, m_src, 1'b0, m_usb & ulk, m_rdy, ulk, m_usb, m_lk, m_conn, m_en},
        32'hFFFFFFFF);
  endtask : st

  task automatic co;
    @(negedge core_clk);
    chk({osc_en, src, pll_en, conn, usb_en}, {m_osc, m_src, m_en, m_conn, m_usb});
    @(posedge core_clk);
  endtask : co

  // Settle first so a path switch is not counted as a toggle
  task automatic run(input logic [4:0] m, input int n);
    repeat (2) @(posedge core_clk);
    t0 = tc;
    c0 = cc;
    mask <= m;
    repeat (n) @(posedge core_clk);
    mask <= '0;
    repeat (8) @(posedge core_clk);
  endtask : run

  task automatic pulse(input logic [4:0] m, input int k);
    det <= 1'b1;
    repeat (k) begin
      mask <= m;
      @(posedge core_clk);
      mask <= '0;
      @(posedge core_clk);
    end
    det <= 1'b0;
  endtask : pulse

  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    co;
    st;
    rdc(REG_USB_CTRL, 32'h50, 32'hF1);
    rdc(8'h20, 32'h0, 32'hFFFFFFFF);
    wr(REG_PLL_CFG, 32'h7FFF00FF);
    rdc(REG_PLL_CFG, m_cfg, 32'hFFFFFFFF);
    wr(REG_PLL_CFG, 32'h0);
    wr(REG_SRC_SEL, 32'h2);
    co;
    wr(REG_SRC_SEL, 32'h3);
    co;
    run(5'h0F, 40);
    chk(cc[0] - c0[0], tc[2] - t0[2]);
    wr(REG_OSC_CTRL, 32'h1);
    co;
    pulse(5'h02, 7);
    repeat (4) @(posedge core_clk);
    st;
    wr(REG_SRC_SEL, 32'h1);
    co;
    pulse(5'h02, 2);
    repeat (4) @(posedge core_clk);
    m_rdy = 1'b1;
    st;
    wr(REG_SRC_SEL, 32'h1);
    co;
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    m_src = 2'h0;
    co;
    wr(REG_SRC_SEL, 32'h1);
    wr(REG_PLL_CTRL, 32'h3);
    co;
    wr(REG_PLL_CFG, 32'h00010001);
    rdc(REG_PLL_CFG, m_cfg, 32'hFFFFFFFF);
    pulse(5'h02, 3);
    repeat (4) @(posedge core_clk);
    chk({up, dn}, 2'b10);
    pulse(5'h08, 3);
    repeat (4) @(posedge core_clk);
    chk({up, dn}, 2'b01);
    lock <= 1'b1;
    repeat (4) @(posedge core_clk);
    m_lk = 1'b1;
    st;
    wr(REG_PLL_CTRL, 32'h3);
    co;
    run(5'h0F, 40);
    chk(cc[0] - c0[0], tc[3] - t0[3]);
    ulk <= 1'b1;
    wr(REG_USB_CTRL, 32'h51);
    co;
    run(5'h18, 60);
    chk(cc[1] - c0[1], tc[4] - t0[4]);
    wr(REG_USB_CTRL, 32'h50);
    run(5'h18, 120);
    chk(((cc[1] - c0[1]) - (tc[3] - t0[3]) / 6) inside {0, 1}, 1'b1);
    lock <= 1'b0;
    repeat (6) @(posedge core_clk);
    {m_lk, m_conn} = 2'b00;
    co;
    st;
    wr(REG_USB_CTRL, 32'h51);
    for (int s = 0; s < 5; s++) begin
      wr(REG_CLKOUT, 32'h100 | s);
      run(5'h17, 40);
      chk(cc[2] - c0[2], tc[idx[s]] - t0[idx[s]]);
    end
    wr(REG_CLKOUT, 32'h0);
    run(5'h17, 40);
    chk(cc[2] - c0[2], 32'h0);
    lock <= 1'b1;
    repeat (4) @(posedge core_clk);
    m_lk = 1'b1;
    wr(REG_PLL_CTRL, 32'h3);
    wr(REG_PWR_CTRL, 32'h1);
    co;
    final_report;
  end

  // Sequence needs about 760 cycles; this bound is far beyond it
  initial begin
    #200000;
    err_count++;
    final_report;
  end
endmodule : tb
